//--- src/pgt_debounce.sv
`timescale 1ns/1ps
module pgt_debounce
    import pgt_pkg::*;
#(
    parameter int TICKS_PER_MS = CLK_HZ / MS_PER_S
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic raw_i,
    output pgt_manual_t manual_o
);

    typedef struct packed {
        logic [MS_CNT_W-1:0] tick;
        logic [DEB_CNT_W-1:0] high_ms;
        logic [DEB_CNT_W-1:0] win_ms;
        logic level;
        pgt_manual_t ev;
    } pgt_deb_st_t;

    localparam logic [MS_CNT_W-1:0] TICK_LAST = MS_CNT_W'(TICKS_PER_MS - 1);
    localparam logic [DEB_CNT_W-1:0] DEB_N = DEB_CNT_W'(DEB_MS);
    localparam logic [DEB_CNT_W-1:0] OBS_N = DEB_CNT_W'(OBS_MS);

    pgt_deb_st_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.ev.rise = 1'b0;
        s_d.ev.fall = 1'b0;
        if (s_q.tick == TICK_LAST) begin
            s_d.tick = '0;
            // judged once per millisecond, so a sub-ms glitch is seen only if it spans a sample
            if (raw_i != s_q.level) begin
                if (s_q.high_ms != DEB_N) begin
                    s_d.high_ms = s_q.high_ms + 1'b1;
                end
            end
            if (s_q.win_ms != OBS_N) begin
                s_d.win_ms = s_q.win_ms + 1'b1;
            end
            if (raw_i == s_q.level) begin
                if (s_q.win_ms == OBS_N || s_q.high_ms == '0) begin
                    s_d.win_ms = '0;
                    s_d.high_ms = '0;
                end
            end
            if (s_d.high_ms == DEB_N) begin
                s_d.level = ~s_q.level;
                s_d.ev.rise = ~s_q.level;
                s_d.ev.fall = s_q.level;
                s_d.high_ms = '0;
                s_d.win_ms = '0;
            end
        end else begin
            s_d.tick = s_q.tick + 1'b1;
        end
        s_d.ev.level = s_d.level;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign manual_o = s_q.ev;

endmodule

//--- src/pgt_pkg.sv
package pgt_pkg;

    // clock and time base
    localparam int CLK_HZ = 100_000_000;
    localparam int MS_PER_S = 1000;

    // interval code: units of 100 ms
    localparam int IVL_W = 17;
    localparam int IVL_UNIT_MS = 100;
    localparam int IVL_MAX_UNITS = 72000;
    localparam int IVL_SETTINGS = 1650;

    // timing figures in milliseconds
    localparam int OFF_GUARD_MS = 50;
    localparam int DEB_MS = 20;
    localparam int OBS_MS = 30;
    localparam int START_LATENCY_MS = 10;
    localparam int JITTER_MS = 5;

    localparam int MS_CNT_W = 20;
    localparam int IVL_CNT_W = 24;
    localparam int DEB_CNT_W = 8;

    typedef enum logic [2:0] {
        PGT_ST_POR   = 3'b000,
        PGT_ST_READ  = 3'b001,
        PGT_ST_IDLE  = 3'b010,
        PGT_ST_ON    = 3'b011,
        PGT_ST_GUARD = 3'b100,
        PGT_ST_MHOLD = 3'b101,
        PGT_ST_WAIT  = 3'b110
    } pgt_state_t;

    // debounced manual input events
    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } pgt_manual_t;

endpackage

//--- src/pgt_timer.sv
`timescale 1ns/1ps
// Summary of operation
// - resistor code is read once after reset, never again.
// - after reading, mode is chosen from the mode-select level.
// - timer mode repeats a gate pulse every programmed interval.
// - interval is measured between successive gate falling edges.
// - completion pulse shortens the gate pulse in timer mode.
// - one-shot mode gives a single pulse after startup.
// - in one-shot, each valid manual request gives one more pulse.
// - completion before interval minus 50 ms releases gate at once.
// - manual high during reset or reading aborts and restarts reading.
// - manual request valid only if high 20 ms within 30 ms window.
// - after reading, high on shared pin means manual request.
// - manual input is debounced on both edges.
// - manual request is ignored while gate is already low.
// - validated manual request drives gate low within 10 ms.
// - manual pulse lasts interval minus 50 ms or until completion.
// - manual request clears counters; they resume after release.
// - manual start point may wander about 5 ms either way.
// - holding the manual input keeps the gate low meanwhile.
// - completion pulses are ignored while manual input is high.
// - 1650 interval settings from 100 ms to 7200 s.
// - interval code is the digitized resistor result, 100 ms units.
// - gate output is active low, low switches the transistor on.
// - gate goes low right after the reading completes.
// - only the first rising completion edge per interval counts.
// - without completion, gate goes high for the last 50 ms.
module pgt_timer
    import pgt_pkg::*;
#(
    parameter int TICKS_PER_MS = CLK_HZ / MS_PER_S
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic interval_set_manual_on_i,
    input wire logic [IVL_W-1:0] interval_code_i,
    input wire logic interval_code_valid_i,
    input wire logic done_i,
    input wire logic mode_timer_i,
    output logic gate_drive_n_o,
    output logic reading_o,
    output logic [IVL_W-1:0] programmed_interval_o
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        pgt_state_t st;
        logic [IVL_W-1:0] ivl;
        logic [MS_CNT_W-1:0] tick;
        logic [IVL_CNT_W-1:0] ms;
        logic done_prev;
        logic done_seen;
        logic timer_mode;
        logic gate_n;
        logic reading;
    } pgt_st_t;

    localparam logic [MS_CNT_W-1:0] TICK_LAST = MS_CNT_W'(TICKS_PER_MS - 1);
    localparam logic [IVL_CNT_W-1:0] GUARD_N = IVL_CNT_W'(OFF_GUARD_MS);
    localparam logic [IVL_CNT_W-1:0] UNIT_N = IVL_CNT_W'(IVL_UNIT_MS);

    pgt_st_t s_q, s_d;
    pgt_manual_t man;
    logic ms_tick;
    logic done_rise;
    logic [IVL_CNT_W-1:0] ivl_ms;
    logic [IVL_CNT_W-1:0] on_ms;

    ////////////////////////////////////////////////////////////////////////
    // manual input filter

    pgt_debounce #(
        .TICKS_PER_MS(TICKS_PER_MS)
    ) u_deb (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .raw_i(interval_set_manual_on_i),
        .manual_o(man)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencing

    function automatic logic [IVL_CNT_W-1:0] code_to_ms(input logic [IVL_W-1:0] c);
        code_to_ms = IVL_CNT_W'(c) * UNIT_N;
    endfunction

    always_comb begin
        ms_tick = (s_q.tick == TICK_LAST);
        done_rise = done_i & ~s_q.done_prev;
        ivl_ms = code_to_ms(s_q.ivl);
        // a code shorter than the guard still gets a one-ms window
        on_ms = (ivl_ms > GUARD_N) ? ivl_ms - GUARD_N : IVL_CNT_W'(1);
        s_d = s_q;
        s_d.done_prev = done_i;
        s_d.tick = ms_tick ? '0 : s_q.tick + 1'b1;
        if (ms_tick) begin
            s_d.ms = s_q.ms + 1'b1;
        end
        case (s_q.st)
            PGT_ST_POR: begin
                s_d.reading = 1'b1;
                s_d.gate_n = 1'b1;
                if (!interval_set_manual_on_i) begin
                    s_d.st = PGT_ST_READ;
                end
            end
            PGT_ST_READ: begin
                if (interval_set_manual_on_i) begin
                    s_d.st = PGT_ST_POR;
                end else if (interval_code_valid_i) begin
                    s_d.ivl = interval_code_i;
                    s_d.timer_mode = mode_timer_i;
                    s_d.reading = 1'b0;
                    s_d.gate_n = 1'b0;
                    s_d.done_seen = 1'b0;
                    s_d.ms = '0;
                    s_d.tick = '0;
                    s_d.st = PGT_ST_ON;
                end
            end
            PGT_ST_ON: begin
                if (done_rise && !s_q.done_seen && !man.level) begin
                    s_d.done_seen = 1'b1;
                    s_d.gate_n = 1'b1;
                    s_d.st = s_q.timer_mode ? PGT_ST_GUARD : PGT_ST_IDLE;
                end else if (s_d.ms >= on_ms) begin
                    // next-value compare keeps the low time at exactly on_ms
                    s_d.gate_n = 1'b1;
                    s_d.st = s_q.timer_mode ? PGT_ST_GUARD : PGT_ST_IDLE;
                end
            end
            PGT_ST_GUARD: begin
                if (man.rise) begin
                    s_d.ms = '0;
                    s_d.tick = '0;
                    s_d.gate_n = 1'b0;
                    s_d.st = PGT_ST_MHOLD;
                end else if (s_d.ms >= ivl_ms) begin
                    s_d.ms = '0;
                    s_d.gate_n = 1'b0;
                    s_d.done_seen = 1'b0;
                    s_d.st = PGT_ST_ON;
                end
            end
            PGT_ST_IDLE: begin
                s_d.ms = '0;
                if (man.rise) begin
                    s_d.tick = '0;
                    s_d.gate_n = 1'b0;
                    s_d.st = PGT_ST_MHOLD;
                end
            end
            PGT_ST_MHOLD: begin
                s_d.ms = '0;
                s_d.done_seen = 1'b0;
                if (man.fall) begin
                    s_d.st = PGT_ST_ON;
                end
            end
            default: begin
                s_d.st = PGT_ST_POR;
                s_d.gate_n = 1'b1;
            end
        endcase
        // gate-low time ignores new manual requests via state choice
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0;
            s_q.gate_n <= 1'b1;
            s_q.reading <= 1'b1;
            s_q.st <= PGT_ST_POR;
        end else begin
            s_q <= s_d;
        end
    end

    assign gate_drive_n_o = s_q.gate_n;
    assign reading_o = s_q.reading;
    assign programmed_interval_o = s_q.ivl;

endmodule

//--- verification/pgt_mcu_model.sv
`timescale 1ns/1ps
module pgt_mcu_model (
    input wire logic ref_clk_i,
    input wire logic gate_drive_n_i,
    input wire logic [31:0] delay_i,
    output logic done_o
);
    int cnt;
    initial begin
        done_o = 1'b0;
        cnt = 0;
    end
    // unpowered while gate is high, so done cannot rise then; zero delay never answers
    always @(posedge ref_clk_i) begin
        cnt <= gate_drive_n_i ? 0 : cnt + 1;
        // one rising edge per wake, high for up to 100 ns, cut short when the gate goes high
        done_o <= !gate_drive_n_i && delay_i != 0 && cnt >= delay_i && cnt < delay_i + 10;
    end
endmodule

//--- verification/pgt_timer_checker.sv
`timescale 1ns/1ps
module pgt_timer_checker
    import pgt_pkg::*;
#(
    parameter int TICKS_PER_MS = 10
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic interval_set_manual_on_i,
    input wire logic [IVL_W-1:0] interval_code_i,
    input wire logic interval_code_valid_i,
    input wire logic done_i,
    input wire logic mode_timer_i,
    input wire logic gate_drive_n_o,
    input wire logic reading_o,
    input wire logic [IVL_W-1:0] programmed_interval_o
);
    localparam int T = TICKS_PER_MS;
    wire m = interval_set_manual_on_i;
    wire g = gate_drive_n_o;
    int hi_q, lo_q, run_q, low_q, per_q, ivl;
    logic seen_q;
    assign ivl = int'(programmed_interval_o) * IVL_UNIT_MS * T;
    // any manual activity since reading voids the plain timing checks
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {hi_q, lo_q, run_q, low_q, per_q} <= '0;
            seen_q <= 1'b0;
        end else begin
            hi_q <= (m && g && !reading_o) ? hi_q + 1 : 0;
            lo_q <= m ? 0 : lo_q + 1;
            run_q <= m ? run_q + 1 : 0;
            low_q <= g ? 0 : low_q + 1;
            per_q <= reading_o ? 0 : $fell(g) ? 1 : per_q + (per_q != 0);
            seen_q <= !reading_o && (seen_q || m);
        end
    end
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);
    code_take_a: assert property (reading_o && interval_code_valid_i && !m
        |=> !reading_o && !g && programmed_interval_o == $past(interval_code_i))
        else $error("code not taken");
    read_once_a: assert property (!reading_o
        |=> !reading_o && $stable(programmed_interval_o)) else $error("reread");
    read_abort_a: assert property (reading_o && m |=> reading_o)
        else $error("read not aborted");
    done_cut_a: assert property ($rose(done_i) && !g && lo_q > OBS_MS * T
        |-> ##[1:3] g) else $error("done not obeyed");
    press_start_a: assert property (hi_q <= (DEB_MS + START_LATENCY_MS) * T)
        else $error("late manual start");
    glitch_a: assert property ($fell(g) && !mode_timer_i
        |-> $past(reading_o) || run_q >= (DEB_MS - 1) * T) else $error("glitch start");
    pulse_len_a: assert property (!seen_q && !g
        |-> low_q < ivl - OFF_GUARD_MS * T) else $error("pulse too long");
    period_a: assert property ($fell(g) && mode_timer_i && !seen_q && per_q != 0
        |-> per_q == ivl) else $error("wrong period");
endmodule

bind pgt_timer pgt_timer_checker #(.TICKS_PER_MS(TICKS_PER_MS)) chk (.*);

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    import pgt_pkg::*;
    localparam int T = 10;
    logic clk, rst_n, pin, vld, mode, done, gate, rd, g;
    logic [IVL_W-1:0] code, ivl;
    logic [31:0] rs;
    int num_errors, n_tests, cyc, dly, per, lim, pr;
    int falls[$], rises[$];

    pgt_timer #(.TICKS_PER_MS(T)) uut (.ref_clk_i(clk), .resetn_i(rst_n),
        .interval_set_manual_on_i(pin), .interval_code_i(code), .interval_code_valid_i(vld),
        .done_i(done), .mode_timer_i(mode), .gate_drive_n_o(gate), .reading_o(rd),
        .programmed_interval_o(ivl));
    pgt_mcu_model mcu (.ref_clk_i(clk), .gate_drive_n_i(gate), .delay_i(dly), .done_o(done));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (g === 1'b1 && gate === 1'b0) falls.push_back(cyc);
        if (g === 1'b0 && gate === 1'b1) rises.push_back(cyc);
        g = gate;
        if (cyc == 40000) begin
            num_errors++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    task automatic chk_n(input int got, input int exp);
        n_tests++;
        if (got != exp) begin
            num_errors++;
            $display("unexpected at %0t: count %0d want %0d", $time, got, exp);
        end
    endtask
    task automatic chk_v(input logic [IVL_W-1:0] got, input logic [IVL_W-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: value %0h want %0h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic press(input int n);
        pin = 1'b1;
        wt(n);
        pin = 1'b0;
    endtask
    // strobe only from the second edge after release, as the core allows
    task automatic start(input logic m, input logic ab);
        rst_n = 1'b0;
        mode = m;
        pin = ab;
        code = IVL_W'(rnd() % 2 + 1);
        per = int'(code) * IVL_UNIT_MS * T;
        lim = per - OFF_GUARD_MS * T;
        wt(5);
        falls.delete();
        rises.delete();
        rst_n = 1'b1;
        wt(1);
        vld = 1'b1;
        wt(1);
        vld = 1'b0;
        if (ab) begin
            chk_v(IVL_W'(rd), 1);
            pin = 1'b0;
            wt(2);
            vld = 1'b1;
            wt(1);
            vld = 1'b0;
        end
        wt(1);
        chk_v(ivl, code);
        chk_v(IVL_W'(rd), 0);
    endtask
    task automatic report_and_stop();
        if (num_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        rs = 32'h664B;
        {rst_n, pin, vld, mode} = '0;
        code = '0;
        dly = 0;
        start(1'b1, 1'b0);
        code = code + 1'b1;
        vld = 1'b1;
        wt(1);
        vld = 1'b0;
        chk_v(ivl, code - 1'b1);
        while (falls.size() < 3) wt(1);
        for (int i = 0; i < 2; i++) begin
            chk_n(rises[i] - falls[i], lim);
            chk_n(falls[i + 1] - falls[i], per);
        end
        dly = int'(rnd() % 250) + 50;
        start(1'b1, 1'b0);
        while (falls.size() < 2) wt(1);
        chk_n(rises[0] - falls[0] inside {[dly:dly + 4]}, 1);
        chk_n(falls[1] - falls[0], per);
        dly = 0;
        start(1'b0, 1'b1);
        wt(4000);
        chk_n(falls.size(), 1);
        chk_n(rises[0] - falls[0], lim);
        press(50);
        wt(600);
        chk_n(falls.size(), 1);
        dly = 200;
        pr = cyc;
        pin = 1'b1;
        wt(1500);
        chk_n(falls[1] - pr inside {[190:300]}, 1);
        chk_v(IVL_W'(gate), 0);
        pin = 1'b0;
        pr = cyc;
        dly = 0;
        wt(2000);
        chk_n(rises[1] - pr inside {[lim:lim + 300]}, 1);
        press(250);
        wt(300);
        press(250);
        wt(2500);
        chk_n(falls.size(), 3);
        report_and_stop();
    end
endmodule
